// ===== src/hbi_consts.svh
// constants for the host port device end and host end
`ifndef HBI_CONSTS_SVH
`define HBI_CONSTS_SVH

// device-internal register byte addresses, event count, mode, style and lane codes on the host port
`define HBI_DEV_INT_STAT    8'hFC
`define HBI_DEV_INT_MASK    8'hFE
`define HBI_DEV_EVENTS      16
`define HBI_MODE_16BIT      1'b0
`define HBI_MODE_8BIT       1'b1
`define HBI_STYLE_SPLIT     1'b0
`define HBI_STYLE_RWSEL     1'b1
`define HBI_LANES_NONE      2'h0
`define HBI_LANES_LOW       2'h1
`define HBI_LANES_HIGH      2'h2
`define HBI_LANES_BOTH      2'h3

// host APB register byte offsets
`define HBI_APB_CTRL        8'h00
`define HBI_APB_CFG         8'h04
`define HBI_APB_WDATA       8'h08
`define HBI_APB_RDATA       8'h0C
`define HBI_APB_STATUS      8'h10
`define HBI_APB_INT_STAT    8'h14
`define HBI_APB_INT_MASK    8'h18

// host field positions
`define HBI_CTRL_READ       8
`define HBI_CTRL_MUXED      9
`define HBI_CTRL_GO         31
`define HBI_CFG_WIDTH       0
`define HBI_CFG_STYLE       1
`define HBI_INT_DONE        0
`define HBI_INT_DEV         1

// host pin phase end counts in mclk cycles, counted from zero
`define HBI_SETUP_CYC       4'h3
`define HBI_STROBE_CYC      4'h8
`define HBI_HOLD_CYC        4'h3

`endif

// ===== src/hbi_pkg.sv
// types shared by the two ends of the host port
package hbi_pkg;
	typedef struct packed {
		logic        csN;
		logic        wrN;
		logic        rdN;
		logic        ale;
		logic        width;
		logic        style;
		logic [7:0]  addr;
		logic [15:0] data;
	} hbi_pins_t;

	typedef enum logic [2:0] {
		H_IDLE, H_ADDR, H_LATCH, H_SETUP, H_STROBE, H_HOLD
	} hbi_hstate_t;
endpackage

// ===== src/hbi_if.sv
// pin bundle joining the host end to the device end
`timescale 1ns/1ps
`default_nettype none
interface hbi_if;
	logic        chipSelectN;
	logic        writeStrobeN;  // read_write_select in rw-select style
	logic        readStrobeN;   // data_strobe_n in rw-select style
	logic        addressLatchEnable;
	logic        busWidthSelect;
	logic        strobeStyleSelect;
	logic [7:0]  hostAddressLines;
	logic [15:0] hostDataOut;
	logic [1:0]  hostDataOe;
	logic [15:0] devDataOut;
	logic [1:0]  devDataOe;
	logic [15:0] hostDataLines;
	logic        intReqOe;
	logic        interruptRequestN;

	// per byte lane: device wins, then host, undriven reads low
	assign hostDataLines[7:0] = devDataOe[0] ? devDataOut[7:0] :
		hostDataOe[0] ? hostDataOut[7:0] : 8'h00;
	assign hostDataLines[15:8] = devDataOe[1] ? devDataOut[15:8] :
		hostDataOe[1] ? hostDataOut[15:8] : 8'h00;
	// open drain with pull-up
	assign interruptRequestN = ~intReqOe;

	modport device (
		input  chipSelectN, writeStrobeN, readStrobeN, addressLatchEnable,
		input  busWidthSelect, strobeStyleSelect, hostAddressLines,
		input  hostDataLines,
		output devDataOut, devDataOe, intReqOe
	);
	modport host (
		output chipSelectN, writeStrobeN, readStrobeN, addressLatchEnable,
		output busWidthSelect, strobeStyleSelect, hostAddressLines,
		output hostDataOut, hostDataOe,
		input  hostDataLines, interruptRequestN
	);
endinterface
`default_nettype wire

// ===== src/hbi_device.sv
// device end of the host port: pin decode, register access, interrupt
`timescale 1ns/1ps
`default_nettype none
`include "hbi_consts.svh"

// How it works
// - width select low is 16-bit, high 8-bit
// - style select: split strobes or rw-select
// - drive data bus only during reads
// - 8-bit mode ignores upper data byte
// - 16-bit mode ignores address bit zero
// - split style: write under write strobe
// - split style: read under read strobe
// - rw-select style: select high reads
// - rw-select style: write on strobe rise
// - interrupt pulls low while unmasked source set
// - no read or write accepted without chip select
// - latch transparent while latch enable high
// - latch enable fall holds the address
// - separate buses: host holds latch enable high
// - shared bus: host latches address first
module hbi_device
(
	// clock and reset
	input  wire logic                        mclk,
	input  wire logic                        rst_n,
	// host pins
	hbi_if.device                            pins,
	// internal register access
	output logic [7:0]                       regAddr,
	output logic [15:0]                      regWrData,
	output logic [1:0]                       regWrBe,
	output logic                             regWr,
	input  wire logic [15:0]                 regRdData,
	// interrupt sources, one-cycle pulses
	input  wire logic [`HBI_DEV_EVENTS-1:0]  events,
	output logic                             irq
);
	typedef struct packed {
		// synchronised pins and the strobe and chip-select levels one cycle back
		hbi_pkg::hbi_pins_t         s1;
		hbi_pkg::hbi_pins_t         s2;
		logic                       prevWr;
		logic                       prevRd;
		logic                       prevCs;
		// address latch and internal registers
		logic [7:0]                 addrHold;
		logic [`HBI_DEV_EVENTS-1:0] intStat;
		logic [`HBI_DEV_EVENTS-1:0] intMask;
		// registered outputs
		logic [15:0]                dOut;
		logic [1:0]                 dOe;
		logic                       intOe;
		logic [7:0]                 wAddr;
		logic [15:0]                wData;
		logic [1:0]                 wBe;
		logic                       wStb;
	} dev_state_t;

	dev_state_t             st;
	dev_state_t             next_st;
	hbi_pkg::hbi_pins_t     raw;
	hbi_pkg::hbi_pins_t     p;
	// combinational helpers
	logic [7:0]             a;
	logic                   rdAct;
	logic                   wrEnd;
	logic [15:0]            word;
	logic [15:0]            wdat;
	logic [1:0]             be;
	logic                   isStat;
	logic                   isMask;
	logic [`HBI_DEV_EVENTS-1:0] clr;
	logic [1:0]             lanes;
	logic [15:0]            laneMask;

	// idle select, strobe and latch enable pins read high so no false strobe edge at release
	localparam hbi_pkg::hbi_pins_t IDLE_PINS = '{csN: 1'b1, wrN: 1'b1,
		rdN: 1'b1, ale: 1'b1, width: `HBI_MODE_16BIT,
		style: `HBI_STYLE_SPLIT, addr: 8'h00, data: 16'h0000};

	// pins gathered into one word for the synchroniser
	assign raw = '{csN: pins.chipSelectN, wrN: pins.writeStrobeN,
		rdN: pins.readStrobeN, ale: pins.addressLatchEnable,
		width: pins.busWidthSelect, style: pins.strobeStyleSelect,
		addr: pins.hostAddressLines, data: pins.hostDataLines};

	always_comb
	begin
		next_st = st;

		// two-flop synchroniser; only s2 is looked at
		next_st.s1 = raw;
		next_st.s2 = st.s1;
		p = st.s2;
		next_st.prevWr = p.wrN;
		next_st.prevRd = p.rdN;
		next_st.prevCs = p.csN;

		// address latch: follows the pins while enabled, else holds
		if (p.ale)
			next_st.addrHold = p.addr;
		a = p.ale ? p.addr : st.addrHold;
		if (p.width == `HBI_MODE_16BIT)
			a[0] = 1'b0;

		// strobe decode
		if (p.style == `HBI_STYLE_SPLIT)
		begin
			rdAct = !p.csN && !p.rdN;
			wrEnd = !st.prevCs && !st.prevWr && p.wrN;
		end
		else
		begin
			rdAct = !p.csN && !p.rdN && p.wrN;
			// direction taken as it stood while the strobe was low
			wrEnd = !st.prevCs && !st.prevRd && p.rdN && !st.prevWr;
		end

		// write data: 8-bit mode reads the low lines only
		if (p.width == `HBI_MODE_8BIT)
		begin
			wdat = {p.data[7:0], p.data[7:0]};
			be = a[0] ? `HBI_LANES_HIGH : `HBI_LANES_LOW;
		end
		else
		begin
			wdat = p.data;
			be = `HBI_LANES_BOTH;
		end
		laneMask = {{8{be[1]}}, {8{be[0]}}};

		// internal status and mask are word aligned at the top of the map
		isStat = {a[7:1], 1'b0} == `HBI_DEV_INT_STAT;
		isMask = {a[7:1], 1'b0} == `HBI_DEV_INT_MASK;
		word = isStat ? st.intStat : isMask ? st.intMask : regRdData;
		clr = '0;
		if (wrEnd && isStat)
			clr = wdat & laneMask;
		// mask bytes follow the lanes being written
		if (wrEnd && isMask)
		begin
			if (be[0])
				next_st.intMask[7:0] = wdat[7:0];
			if (be[1])
				next_st.intMask[15:8] = wdat[15:8];
		end

		// a new event beats a clear in the same cycle
		next_st.intStat = (st.intStat & ~clr) | events;
		next_st.intOe = |(next_st.intStat & next_st.intMask);

		// register bus: internal registers are not passed on
		next_st.wStb = wrEnd && !isStat && !isMask;
		next_st.wAddr = a;
		next_st.wData = wdat;
		next_st.wBe = be;

		// read path: 8-bit mode serves the addressed byte on the low lane
		unique case ({p.width, a[0]})
			{`HBI_MODE_8BIT, 1'b1}:
			begin
				next_st.dOut = {8'h00, word[15:8]};
				lanes = `HBI_LANES_LOW;
			end
			{`HBI_MODE_8BIT, 1'b0}:
			begin
				next_st.dOut = {8'h00, word[7:0]};
				lanes = `HBI_LANES_LOW;
			end
			default:
			begin
				next_st.dOut = word;
				lanes = `HBI_LANES_BOTH;
			end
		endcase
		next_st.dOe = rdAct ? lanes : `HBI_LANES_NONE;
	end

	// one register stage holds the whole state; reset is synchronous
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			st <= '0;
			st.s1 <= IDLE_PINS;
			st.s2 <= IDLE_PINS;
			st.prevWr <= 1'b1;
			st.prevRd <= 1'b1;
			st.prevCs <= 1'b1;
		end
		else
			st <= next_st;
	end

	// data lines driven only during reads, interrupt pin pull-down
	assign pins.devDataOut = st.dOut;
	assign pins.devDataOe = st.dOe;
	assign pins.intReqOe = st.intOe;
	assign irq = st.intOe;

	// internal register bus
	assign regAddr = st.wAddr;
	assign regWrData = st.wData;
	assign regWrBe = st.wBe;
	assign regWr = st.wStb;
endmodule // hbi_device
`default_nettype wire

// ===== src/hbi_host.sv
// host end of the host port: APB command registers and pin sequencer
//
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "hbi_consts.svh"
module hbi_host
(
	// clock and reset
	input  wire logic         mclk,
	input  wire logic         rst_n,
	// APB slave
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [7:0]   paddr,
	input  wire logic [31:0]  pwdata,
	output logic [31:0]       prdata,
	output logic              pready,
	output logic              pslverr,
	// interrupt
	output logic              irq,
	// device pins
	hbi_if.host               pins
);
	typedef struct packed {
		hbi_pkg::hbi_hstate_t fsm;
		logic [3:0]   cnt;
		logic [7:0]   cAddr;
		logic         cRead;
		logic         cMuxed;
		logic         width;
		logic         style;
		logic [15:0]  wdata;
		logic [15:0]  rdata;
		logic [1:0]   intStat;
		logic [1:0]   intMask;
		logic [31:0]  prd;
		logic [15:0]  d1;
		logic [15:0]  d2;
		logic         i1;
		logic         i2;
		logic         csN;
		logic         wrN;
		logic         rdN;
		logic         ale;
		logic [7:0]   aOut;
		logic [15:0]  dOut;
		logic [1:0]   dOe;
	} host_state_t;

	host_state_t  st;
	host_state_t  next_st;
	logic         wr;
	logic [1:0]   set;
	logic [1:0]   clr;
	logic [1:0]   lanes;

	always_comb
	begin
		next_st = st;
		set = '0;
		clr = '0;
		wr = psel && penable && pwrite;
		next_st.d1 = pins.hostDataLines;
		next_st.d2 = st.d1;
		next_st.i1 = pins.interruptRequestN;
		next_st.i2 = st.i1;
		lanes = st.width ? `HBI_LANES_LOW : `HBI_LANES_BOTH;
		// read data registered in the setup cycle, so pready is constant
		if (psel && !penable)
			unique case (paddr)
				`HBI_APB_CTRL: next_st.prd = {22'h0, st.cMuxed, st.cRead,
					st.cAddr};
				`HBI_APB_CFG: next_st.prd = {30'h0, st.style, st.width};
				`HBI_APB_WDATA: next_st.prd = {16'h0, st.wdata};
				`HBI_APB_RDATA: next_st.prd = {16'h0, st.rdata};
				`HBI_APB_STATUS: next_st.prd = {31'h0,
					st.fsm != hbi_pkg::H_IDLE};
				`HBI_APB_INT_STAT: next_st.prd = {30'h0, st.intStat};
				`HBI_APB_INT_MASK: next_st.prd = {30'h0, st.intMask};
				default: next_st.prd = 32'h0;
			endcase
		if (wr && paddr == `HBI_APB_CFG && st.fsm == hbi_pkg::H_IDLE)
		begin
			next_st.width = pwdata[`HBI_CFG_WIDTH];
			next_st.style = pwdata[`HBI_CFG_STYLE];
		end
		if (wr && paddr == `HBI_APB_WDATA)
			next_st.wdata = pwdata[15:0];
		if (wr && paddr == `HBI_APB_INT_MASK)
			next_st.intMask = pwdata[1:0];
		if (wr && paddr == `HBI_APB_INT_STAT)
			clr = pwdata[1:0];
		next_st.cnt = st.cnt + 4'h1;
		unique case (st.fsm)
			hbi_pkg::H_IDLE:
			begin
				next_st.csN = 1'b1;
				next_st.wrN = 1'b1;
				next_st.rdN = 1'b1;
				next_st.ale = 1'b1;
				next_st.dOe = `HBI_LANES_NONE;
				next_st.cnt = 4'h0;
				if (wr && paddr == `HBI_APB_CTRL && pwdata[`HBI_CTRL_GO])
				begin
					next_st.cAddr = pwdata[7:0];
					if (!st.width)
						next_st.cAddr[0] = 1'b0;
					next_st.cRead = pwdata[`HBI_CTRL_READ];
					next_st.cMuxed = pwdata[`HBI_CTRL_MUXED];
					next_st.fsm = pwdata[`HBI_CTRL_MUXED] ?
						hbi_pkg::H_ADDR : hbi_pkg::H_SETUP;
				end
			end
			hbi_pkg::H_ADDR:
			begin
				// address rides the low data lines, tied to the address pins
				next_st.aOut = st.cAddr;
				next_st.dOut = {8'h00, st.cAddr};
				next_st.dOe = `HBI_LANES_BOTH;
				next_st.ale = 1'b1;
				if (st.cnt == `HBI_SETUP_CYC)
				begin
					next_st.cnt = 4'h0;
					next_st.fsm = hbi_pkg::H_LATCH;
				end
			end
			hbi_pkg::H_LATCH:
			begin
				next_st.ale = 1'b0;
				if (st.cnt == `HBI_SETUP_CYC)
				begin
					next_st.cnt = 4'h0;
					next_st.fsm = hbi_pkg::H_SETUP;
				end
			end
			hbi_pkg::H_SETUP:
			begin
				next_st.csN = 1'b0;
				next_st.wrN = st.style ? st.cRead : 1'b1;
				next_st.dOut = st.width ? {8'h00, st.wdata[7:0]} : st.wdata;
				next_st.dOe = st.cRead ? `HBI_LANES_NONE : `HBI_LANES_BOTH;
				// upper lines held low in 8-bit mode
				if (!st.cRead && st.width)
					next_st.dOut[15:8] = 8'h00;
				next_st.aOut = st.cMuxed ? next_st.dOut[7:0] : st.cAddr;
				if (st.cMuxed && st.cRead)
					next_st.aOut = 8'h00;
				if (st.cnt == `HBI_SETUP_CYC)
				begin
					next_st.cnt = 4'h0;
					next_st.fsm = hbi_pkg::H_STROBE;
				end
			end
			hbi_pkg::H_STROBE:
			begin
				if (st.style)
					next_st.rdN = 1'b0;
				else if (st.cRead)
					next_st.rdN = 1'b0;
				else
					next_st.wrN = 1'b0;
				if (st.cnt == `HBI_STROBE_CYC)
				begin
					next_st.cnt = 4'h0;
					next_st.rdN = 1'b1;
					next_st.wrN = st.style ? st.cRead : 1'b1;
					if (st.cRead)
						next_st.rdata = st.width ? {8'h00, st.d2[7:0]} : st.d2;
					next_st.fsm = hbi_pkg::H_HOLD;
				end
			end
			hbi_pkg::H_HOLD:
			begin
				if (st.cnt == `HBI_HOLD_CYC)
				begin
					set[`HBI_INT_DONE] = 1'b1;
					next_st.fsm = hbi_pkg::H_IDLE;
				end
			end
		endcase
		if (!next_st.dOe[1] || st.width)
			next_st.dOe = next_st.dOe & lanes;
		set[`HBI_INT_DEV] = !st.i2;
		// a new event beats a clear in the same cycle
		next_st.intStat = (st.intStat & ~clr) | set;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			st <= '0;
			st.fsm <= hbi_pkg::H_IDLE;
			st.i1 <= 1'b1;
			st.i2 <= 1'b1;
			st.csN <= 1'b1;
			st.wrN <= 1'b1;
			st.rdN <= 1'b1;
			st.ale <= 1'b1;
		end
		else
			st <= next_st;
	end

	assign prdata = st.prd;
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign irq = |(st.intStat & st.intMask);
	assign pins.chipSelectN = st.csN;
	assign pins.writeStrobeN = st.wrN;
	assign pins.readStrobeN = st.rdN;
	assign pins.addressLatchEnable = st.ale;
	assign pins.busWidthSelect = st.width;
	assign pins.strobeStyleSelect = st.style;
	assign pins.hostAddressLines = st.aOut;
	assign pins.hostDataOut = st.dOut;
	assign pins.hostDataOe = st.dOe;
endmodule // hbi_host
`default_nettype wire

// ===== tb/hbi_chk.sv
// pin-level assertions between the host end and the device end
`timescale 1ns/1ps
`default_nettype none
module hbi_chk
(
	// clock and reset
	input wire logic        mclk,
	input wire logic        rst_n,
	// pins
	input wire logic        chipSelectN,
	input wire logic        writeStrobeN,
	input wire logic        readStrobeN,
	input wire logic        addressLatchEnable,
	input wire logic        busWidthSelect,
	input wire logic [7:0]  hostAddressLines,
	input wire logic [1:0]  hostDataOe,
	input wire logic [1:0]  devDataOe,
	input wire logic [15:0] hostDataLines
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	a_no_contention: assert property (
		hostDataOe != 2'h0 |-> devDataOe == 2'h0)
		else $error("both ends drive the data bus");
	a_no_write_drive: assert property (
		!writeStrobeN |-> devDataOe == 2'h0)
		else $error("device drives data during a write");
	a_read_drive: assert property (
		$fell(readStrobeN) && !chipSelectN && writeStrobeN
		|-> ##[2:4] devDataOe != 2'h0)
		else $error("read data not driven in time");
	a_read_release: assert property (
		$rose(readStrobeN) |-> ##4 devDataOe == 2'h0)
		else $error("data bus not released after strobe");
	a_narrow_lane: assert property (
		busWidthSelect && devDataOe != 2'h0 |-> devDataOe == 2'h1)
		else $error("upper lane driven in 8-bit mode");
	a_upper_idle: assert property (
		busWidthSelect |-> !hostDataOe[1])
		else $error("host drives upper lane in 8-bit mode");
	a_addr_even: assert property (
		!busWidthSelect && !chipSelectN && addressLatchEnable
		|-> !hostAddressLines[0])
		else $error("address bit zero set in 16-bit mode");
	a_latch_addr: assert property (
		$fell(addressLatchEnable) |-> ($past(hostDataLines) & 16'h00FF)
		== {8'h00, $past(hostAddressLines)})
		else $error("address not on low data byte at latch");
	a_strobe_in_cs: assert property (
		!readStrobeN |-> !chipSelectN)
		else $error("strobe outside chip select");
	a_idle_quiet: assert property (
		chipSelectN [*5] |-> devDataOe == 2'h0)
		else $error("device drives while deselected");

	c_read: cover property ($fell(readStrobeN) && writeStrobeN);
	c_rw_write: cover property ($rose(readStrobeN) && !writeStrobeN);
	c_muxed: cover property ($fell(addressLatchEnable));
endmodule // hbi_chk
`default_nettype wire

// ===== tb/testbench.sv
// self-checking bench: APB drives the host end, which drives the device
`timescale 1ns/1ps
`default_nettype none
`include "hbi_consts.svh"
module testbench;
	logic        mclk;
	logic        rst_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        hostIrq;
	logic        devIrq;
	logic [7:0]  regAddr;
	logic [15:0] regWrData;
	logic [1:0]  regWrBe;
	logic        regWr;
	logic [15:0] events;
	logic [15:0] regRdData;
	logic [7:0]  wrAddr;
	logic [15:0] wrData;
	logic [1:0]  wrBe;
	int          wrCount = 0;
	int          failures;
	int          checks_done;
	logic [31:0] rd;

	hbi_if hbi_if_inst ();
	hbi_host hbi_host_inst (.mclk(mclk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(), .irq(hostIrq), .pins(hbi_if_inst.host));
	hbi_device hbi_device_inst (.mclk(mclk), .rst_n(rst_n),
		.pins(hbi_if_inst.device), .regAddr(regAddr),
		.regWrData(regWrData), .regWrBe(regWrBe), .regWr(regWr),
		.regRdData(regRdData), .events(events), .irq(devIrq));
	hbi_chk hbi_chk_inst (.mclk(mclk), .rst_n(rst_n),
		.chipSelectN(hbi_if_inst.chipSelectN),
		.writeStrobeN(hbi_if_inst.writeStrobeN),
		.readStrobeN(hbi_if_inst.readStrobeN),
		.addressLatchEnable(hbi_if_inst.addressLatchEnable),
		.busWidthSelect(hbi_if_inst.busWidthSelect),
		.hostAddressLines(hbi_if_inst.hostAddressLines),
		.hostDataOe(hbi_if_inst.hostDataOe),
		.devDataOe(hbi_if_inst.devDataOe),
		.hostDataLines(hbi_if_inst.hostDataLines));

	// each register reads back its own address, so bytes are telling
	assign regRdData = {~regAddr, regAddr};
	always @(posedge mclk)
		if (regWr)
		begin
			wrAddr <= regAddr;
			wrData <= regWrData;
			wrBe <= regWrBe;
			wrCount <= wrCount + 1;
		end

	initial
	begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	task automatic final_report;
		if (failures == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		checks_done++;
		if (got !== exp)
		begin
			$display("wrong value %s expected %h seen %h", what, exp, got);
			failures++;
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20)
		begin
			failures++;
			final_report();
		end
	endtask

	// one pin access; polls the done flag, then clears it
	task automatic access(input logic [1:0] cfg, input logic [31:0] ctrl);
		int n;
		apb(1'b1, `HBI_APB_CFG, {30'h0, cfg});
		apb(1'b1, `HBI_APB_CTRL, ctrl | 32'h80000000);
		n = 0;
		do
		begin
			apb(1'b0, `HBI_APB_INT_STAT, 32'h0);
			n++;
		end
		while (rd[`HBI_INT_DONE] !== 1'b1 && n < 40);
		if (n >= 40)
		begin
			failures++;
			final_report();
		end
		apb(1'b1, `HBI_APB_INT_STAT, 32'h1);
		repeat (2) @(posedge mclk);
	endtask

	// all four width and style pairs, two of them over a shared bus
	task automatic s_modes;
		logic [1:0]  cfg;
		logic [31:0] mux;
		int          c;
		for (int i = 0; i < 4; i++)
		begin
			cfg = i[1:0];
			mux = (i[0] ^ i[1]) ? 32'h200 : 32'h0;
			c = wrCount;
			apb(1'b1, `HBI_APB_WDATA, 32'hA55A);
			access(cfg, mux | 32'h35);
			chk("write count", c + 1, wrCount);
			chk("write addr", cfg[0] ? 8'h35 : 8'h34, wrAddr);
			chk("write data", cfg[0] ? 16'h5A5A : 16'hA55A, wrData);
			chk("write lanes", cfg[0] ? 2'h2 : 2'h3, wrBe);
			access(cfg, mux | 32'h135);
			apb(1'b0, `HBI_APB_RDATA, 32'h0);
			chk("read data", cfg[0] ? 32'hCA : 32'hCB34, rd);
		end
	endtask

	// device interrupt: raise, mask, unmask, service
	task automatic s_irq;
		int c;
		c = wrCount;
		apb(1'b1, `HBI_APB_INT_MASK, 32'h2);
		apb(1'b1, `HBI_APB_WDATA, 32'h8);
		access(2'h0, `HBI_DEV_INT_MASK);
		@(posedge mclk);
		events <= 16'h0008;
		@(posedge mclk);
		events <= 16'h0000;
		repeat (4) @(posedge mclk);
		chk("pin", 1'b0, hbi_if_inst.interruptRequestN);
		chk("device irq", 1'b1, devIrq);
		chk("host irq", 1'b1, hostIrq);
		apb(1'b1, `HBI_APB_WDATA, 32'h0);
		access(2'h0, `HBI_DEV_INT_MASK);
		chk("pin masked", 1'b1, hbi_if_inst.interruptRequestN);
		apb(1'b1, `HBI_APB_INT_STAT, 32'h2);
		@(posedge mclk);
		chk("host irq cleared", 1'b0, hostIrq);
		apb(1'b1, `HBI_APB_WDATA, 32'h8);
		access(2'h0, `HBI_DEV_INT_MASK);
		chk("pin unmasked", 1'b0, hbi_if_inst.interruptRequestN);
		apb(1'b1, `HBI_APB_INT_MASK, 32'h0);
		@(posedge mclk);
		chk("host irq masked", 1'b0, hostIrq);
		access(2'h0, `HBI_DEV_INT_STAT);
		chk("pin serviced", 1'b1, hbi_if_inst.interruptRequestN);
		chk("internal writes", c, wrCount);
		apb(1'b0, 8'h1C, 32'h0);
		chk("unmapped read", 32'h0, rd);
	endtask

	initial
	begin
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		events = 16'h0000;
		failures = 0;
		checks_done = 0;
		repeat (5) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (3) @(posedge mclk);
		s_modes();
		s_irq();
		final_report();
	end
endmodule // testbench
`default_nettype wire
